// File: mmd_params.svh
`ifndef MMD_PARAMS_SVH
`define MMD_PARAMS_SVH

// ****************************************************************
// Register offsets within the relocatable register block.
// ****************************************************************
`define MMD_OFF_EEPOS        7'h37
`define MMD_OFF_MODE         7'h3c
`define MMD_OFF_MAP          7'h3d
`define MMD_OFF_CONFIG       7'h3f

// ****************************************************************
// Field positions.
// ****************************************************************
`define MMD_CFG_ROMPLACE_BIT 7
`define MMD_CFG_ROMPRES_BIT  1
`define MMD_CFG_EEON_BIT     0
`define MMD_MODE_BOOTROM_BIT 7
`define MMD_MODE_SMOD_BIT    6
`define MMD_MODE_MDA_BIT     5

// ****************************************************************
// Reset values and fixed placements.
// ****************************************************************
`define MMD_MAP_RESET        8'h00
`define MMD_EEPOS_RESET      4'h0
`define MMD_EE_OFFSET        12'hd80
`define MMD_EE_BYTES         12'h280
`define MMD_LOW_RAM_TOP      16'h0080
`define MMD_ALT_RAM_BASE     16'h0300
`define MMD_RAM_BYTES_SMALL  11'h300
`define MMD_RAM_BYTES_LARGE  11'h400
`define MMD_ROM_BASE_SMALL   16'ha000
`define MMD_ROM_BASE_LARGE   16'h8000
`define MMD_ROM_BASE_ALT     16'h2000
`define MMD_BOOT_BASE        16'hbe00
`define MMD_BOOT_ENTRY       16'h0080
`define MMD_BOOT_LAST_SMALL  16'h037f
`define MMD_BOOT_LAST_LARGE  16'h047f
`define MMD_BOOT_MAX_BYTES   11'h300

// ****************************************************************
// Timing counts.
// ****************************************************************
`define MMD_MAP_WINDOW_CYC   7'h40
`define MMD_IDLE_CHARS       3'h4

`endif

// File: mmd_pkg.sv
package mmd_pkg;

  // Operating mode latched at reset from the two mode inputs.
  typedef enum logic [1:0] {
    MMD_MODE_BOOT   = 2'b00,
    MMD_MODE_TEST   = 2'b01,
    MMD_MODE_SINGLE = 2'b10,
    MMD_MODE_EXPAND = 2'b11
  } mmd_mode_type;

  // Resource selected by the address decoder.
  typedef enum logic [2:0] {
    MMD_SEL_NONE   = 3'b000,
    MMD_SEL_REGS   = 3'b001,
    MMD_SEL_RAM    = 3'b010,
    MMD_SEL_EEPROM = 3'b011,
    MMD_SEL_ROM    = 3'b100,
    MMD_SEL_BOOT   = 3'b101,
    MMD_SEL_EXT    = 3'b110
  } mmd_sel_type;

  // Bootstrap loader sequencing.
  typedef enum logic [1:0] {
    MMD_BL_IDLE = 2'b00,
    MMD_BL_LOAD = 2'b01,
    MMD_BL_DONE = 2'b10
  } mmd_bl_state_type;

endpackage : mmd_pkg

// File: mmd_boot_loader.sv
`timescale 1ns/1ps
`include "mmd_params.svh"

// ****************************************************************
// Bootstrap loader: stores serial bytes into RAM from the entry address upward.
// ****************************************************************
module mmd_boot_loader import mmd_pkg::*; #(
  parameter int CHAR_CYCLES = 500,
  parameter bit LARGE_RAM   = 1'b0
) (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        enable,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  output logic             wr_en,
  output logic [15:0]      wr_addr,
  output logic [7:0]       wr_data,
  output logic             jump,
  output logic [15:0]      jump_addr,
  output logic             active
);

  localparam int IDLE_LIMIT = CHAR_CYCLES * `MMD_IDLE_CHARS;

  initial begin
    if (CHAR_CYCLES < 1) $error("CHAR_CYCLES must be at least one.");
  end

  // All loader state as one record.
  typedef struct packed {
    mmd_bl_state_type state;
    logic [10:0]      count;
    logic [31:0]      idle;
    logic             wr_en;
    logic [15:0]      wr_addr;
    logic [7:0]       wr_data;
    logic             jump;
  } mmd_bl_type;

  mmd_bl_type cur;
  mmd_bl_type next_cur;
  logic [15:0] last_addr;
  logic [15:0] store_addr;

  assign last_addr = LARGE_RAM ? `MMD_BOOT_LAST_LARGE : `MMD_BOOT_LAST_SMALL;
  // The program lands at the entry address, so with the small RAM the last byte meets the top of RAM.
  assign store_addr = `MMD_BOOT_ENTRY + {5'h0, cur.count};

  // Counts bytes and idle time, and ends on timeout or last byte.
  always_comb begin
    next_cur = cur;
    next_cur.wr_en = 1'b0;
    next_cur.jump  = 1'b0;
    case (cur.state)
      MMD_BL_IDLE: begin
        if (enable) begin
          next_cur.state = MMD_BL_LOAD;
          next_cur.idle  = 32'h0;
          next_cur.count = 11'h0;
        end
      end
      MMD_BL_LOAD: begin
        if (rx_valid && cur.count < `MMD_BOOT_MAX_BYTES) begin
          next_cur.wr_en   = 1'b1;
          next_cur.wr_addr = store_addr;
          next_cur.wr_data = rx_data;
          next_cur.count   = cur.count + 11'h1;
          next_cur.idle    = 32'h0;
          if (store_addr == last_addr) begin
            next_cur.state = MMD_BL_DONE;
            next_cur.jump  = 1'b1;
          end
        end else if (cur.idle >= 32'(IDLE_LIMIT - 1)) begin
          next_cur.state = MMD_BL_DONE;
          next_cur.jump  = 1'b1;
        end else begin
          next_cur.idle = cur.idle + 32'h1;
        end
      end
      MMD_BL_DONE: begin
        next_cur.state = MMD_BL_DONE;
      end
      default: begin
        next_cur.state = MMD_BL_IDLE;
      end
    endcase
  end

  // Registers the loader record.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign wr_en     = cur.wr_en;
  assign wr_addr   = cur.wr_addr;
  assign wr_data   = cur.wr_data;
  assign jump      = cur.jump;
  assign jump_addr = `MMD_BOOT_ENTRY;
  assign active    = (cur.state == MMD_BL_LOAD);

endmodule : mmd_boot_loader

// File: mmd_decoder.sv
// Function
// - Single-chip mode shows no external address or data bus on pins.
// - Expanded mode drives high address on B, low on F, data on C.
// - Read/write output sets port C direction; externals drive only on reads.
// - Bootstrap mode loads up to 768 serial bytes into internal RAM.
// - Loader jumps to $0080 after four idle characters or, with the small RAM, the last byte.
// - Space is 64 Kbyte; paging beyond it works only in expanded and special test modes.
// - Register block decodes at $0000 after reset, movable per 4 Kbyte.
// - Internal RAM relocates to any 4 Kbyte boundary via mapping register.
// - Low 128 RAM bytes sit at $0000 unless registers there, then $0300.
// - Two four-bit fields of one mapping register move RAM and registers.
// - Enabled EEPROM sits at $0D80, movable to $xD80 by its position register.
// - Special test mode forces the ROM-present bit to zero at reset.
// - Single-chip mode forces ROM placement high, covering the vectors.
// - In test mode setting ROM-present brings the ROM back into the map.
// - Normal modes accept one mapping write in the first 64 cycles only.
// - Upper nibble gives RAM top bits; lower nibble gives register top bits.
`timescale 1ns/1ps
`include "mmd_params.svh"

module mmd_decoder import mmd_pkg::*; #(
  parameter bit LARGE_RAM   = 1'b0,
  parameter int CHAR_CYCLES = 500
) (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        mode_b,
  input  wire logic        mode_a,
  input  wire logic        cfg_rom_placement,
  input  wire logic        cfg_rom_present,
  input  wire logic        cfg_eeprom_enable,
  input  wire logic [15:0] cpu_addr,
  input  wire logic [3:0]  cpu_page,
  input  wire logic        cpu_valid,
  input  wire logic        cpu_read,
  input  wire logic [7:0]  cpu_wdata,
  input  wire logic [7:0]  port_c_in,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  output logic [2:0]       sel,
  output logic [15:0]      sel_offset,
  output logic [7:0]       reg_rdata,
  output logic             reg_rvalid,
  output logic [7:0]       ext_rdata,
  output logic [7:0]       port_b_out,
  output logic [7:0]       port_b_oe,
  output logic [7:0]       port_f_out,
  output logic [7:0]       port_f_oe,
  output logic [7:0]       port_c_out,
  output logic [7:0]       port_c_oe,
  output logic [3:0]       page_out,
  output logic             read_write,
  output logic             ram_wr_en,
  output logic [15:0]      ram_wr_addr,
  output logic [7:0]       ram_wr_data,
  output logic             boot_jump,
  output logic [15:0]      boot_jump_addr
);

  // ****************************************************************
  // State record.
  // ****************************************************************
  typedef struct packed {
    mmd_mode_type mode;
    logic         mode_valid;
    logic [7:0]   map;
    logic         map_written;
    logic [6:0]   cycles;
    logic [3:0]   ee_pos;
    logic         rom_place;
    logic         rom_present;
    logic         ee_on;
    logic         boot_rom;
    logic [2:0]   sel;
    logic [15:0]  sel_offset;
    logic [7:0]   reg_rdata;
    logic         reg_rvalid;
    logic [7:0]   ext_rdata;
    logic [7:0]   pb;
    logic [7:0]   pf;
    logic [7:0]   pc;
    logic         bus_oe;
    logic         pc_oe;
    logic [3:0]   page;
    logic         rw;
    logic         ram_wr_en;
    logic [15:0]  ram_wr_addr;
    logic [7:0]   ram_wr_data;
    logic         jump;
    logic [15:0]  jump_addr;
  } mmd_state_type;

  mmd_state_type cur;
  mmd_state_type next_cur;

  logic        bl_wr_en;
  logic [15:0] bl_wr_addr;
  logic [7:0]  bl_wr_data;
  logic        bl_jump;
  logic [15:0] bl_jump_addr;
  logic        special;
  logic        expanded;
  logic [2:0]  dec_sel;
  logic [15:0] dec_off;
  logic        reg_hit;
  logic [6:0]  reg_idx;
  logic        map_wr_ok;

  // ****************************************************************
  // Bootstrap loader.
  // ****************************************************************
  mmd_boot_loader #(
    .CHAR_CYCLES (CHAR_CYCLES),
    .LARGE_RAM   (LARGE_RAM)
  ) u_loader (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .enable    (cur.mode_valid && cur.mode == MMD_MODE_BOOT),
    .rx_valid  (rx_valid),
    .rx_data   (rx_data),
    .wr_en     (bl_wr_en),
    .wr_addr   (bl_wr_addr),
    .wr_data   (bl_wr_data),
    .jump      (bl_jump),
    .jump_addr (bl_jump_addr),
    .active    ()
  );

  // ****************************************************************
  // Address decoding.
  // ****************************************************************

  // Selects one resource for an address; registers win, then RAM.
  function automatic logic [18:0] decode_addr(input logic [15:0] a,
                                              input logic [7:0]  map,
                                              input logic [3:0]  ee_pos,
                                              input logic        ee_on,
                                              input logic        rom_on,
                                              input logic        rom_hi,
                                              input logic        boot_on,
                                              input logic        exp);
    logic [15:0] ram_base;
    logic [15:0] reg_base;
    logic [15:0] low_base;
    logic [15:0] rom_base;
    logic [10:0] ram_len;
    logic [15:0] ee_base;
    ram_base = {map[7:4], 12'h000};
    reg_base = {map[3:0], 12'h000};
    ram_len  = LARGE_RAM ? `MMD_RAM_BYTES_LARGE : `MMD_RAM_BYTES_SMALL;
    low_base = (map[3:0] == map[7:4]) ? ram_base + `MMD_ALT_RAM_BASE : ram_base;
    ee_base  = {ee_pos, `MMD_EE_OFFSET};
    rom_base = rom_hi ? (LARGE_RAM ? `MMD_ROM_BASE_LARGE : `MMD_ROM_BASE_SMALL)
                      : `MMD_ROM_BASE_ALT;
    if (a[15:7] == reg_base[15:7]) begin
      decode_addr = {MMD_SEL_REGS, 16'(a - reg_base)};
    end else if (a >= low_base && a < low_base + `MMD_LOW_RAM_TOP) begin
      decode_addr = {MMD_SEL_RAM, 16'(a - low_base)};
    end else if (a >= ram_base + `MMD_LOW_RAM_TOP
                 && a < ram_base + {5'h0, ram_len}) begin
      decode_addr = {MMD_SEL_RAM, 16'(a - ram_base)};
    // Bounded by distance from the base so a window in the top page cannot wrap.
    end else if (ee_on && a >= ee_base
                 && 16'(a - ee_base) < {4'h0, `MMD_EE_BYTES}) begin
      decode_addr = {MMD_SEL_EEPROM, 16'(a - ee_base)};
    end else if (boot_on && a[15:9] == `MMD_BOOT_BASE >> 9) begin
      decode_addr = {MMD_SEL_BOOT, 16'(a - `MMD_BOOT_BASE)};
    end else if (rom_on && a >= rom_base) begin
      decode_addr = {MMD_SEL_ROM, 16'(a - rom_base)};
    end else if (exp) begin
      decode_addr = {MMD_SEL_EXT, a};
    end else begin
      decode_addr = {MMD_SEL_NONE, a};
    end
  endfunction : decode_addr

  // Bootstrap and test modes are both special; test mode also opens the bus.
  assign special  = (cur.mode == MMD_MODE_BOOT) || (cur.mode == MMD_MODE_TEST);
  assign expanded = (cur.mode == MMD_MODE_EXPAND) || (cur.mode == MMD_MODE_TEST);

  // Current decode of the processor address.
  always_comb begin
    {dec_sel, dec_off} = decode_addr(cpu_addr, cur.map, cur.ee_pos, cur.ee_on,
                                     cur.rom_present, cur.rom_place,
                                     cur.boot_rom && special, expanded);
  end

  assign reg_hit   = cpu_valid && dec_sel == MMD_SEL_REGS;
  assign reg_idx   = dec_off[6:0];
  // Mapping writes: once within 64 cycles in normal modes, always in special.
  assign map_wr_ok = special
                   || (!cur.map_written && cur.cycles < `MMD_MAP_WINDOW_CYC);

  // ****************************************************************
  // Next-state logic.
  // ****************************************************************
  always_comb begin
    next_cur = cur;
    next_cur.reg_rvalid = 1'b0;
    next_cur.ram_wr_en  = 1'b0;
    next_cur.jump       = 1'b0;
    if (cur.cycles < `MMD_MAP_WINDOW_CYC) begin
      next_cur.cycles = cur.cycles + 7'h1;
    end
    // Mode and configuration are caught on the first edge after release.
    if (!cur.mode_valid) begin
      next_cur.mode_valid  = 1'b1;
      next_cur.mode        = mmd_mode_type'({mode_b, mode_a});
      next_cur.rom_place   = cfg_rom_placement;
      next_cur.rom_present = cfg_rom_present;
      next_cur.ee_on       = cfg_eeprom_enable;
      next_cur.boot_rom    = ({mode_b, mode_a} == MMD_MODE_BOOT);
      if ({mode_b, mode_a} == MMD_MODE_TEST) begin
        next_cur.rom_present = 1'b0;
      end
      if ({mode_b, mode_a} == MMD_MODE_SINGLE) begin
        next_cur.rom_place = 1'b1;
      end
    end else begin
      // Register writes.
      if (reg_hit && !cpu_read) begin
        case (reg_idx)
          `MMD_OFF_MAP: begin
            if (map_wr_ok) begin
              next_cur.map         = cpu_wdata;
              next_cur.map_written = 1'b1;
            end
          end
          `MMD_OFF_EEPOS: begin
            next_cur.ee_pos = cpu_wdata[7:4];
          end
          `MMD_OFF_CONFIG: begin
            if (cur.mode == MMD_MODE_TEST) begin
              next_cur.rom_present = cpu_wdata[`MMD_CFG_ROMPRES_BIT];
              next_cur.rom_place   = cpu_wdata[`MMD_CFG_ROMPLACE_BIT];
              next_cur.ee_on       = cpu_wdata[`MMD_CFG_EEON_BIT];
            end
          end
          `MMD_OFF_MODE: begin
            if (special) begin
              next_cur.boot_rom = cpu_wdata[`MMD_MODE_BOOTROM_BIT];
            end
          end
          default: begin
            next_cur.map = cur.map;
          end
        endcase
      end
      // Register reads answer one cycle later.
      if (reg_hit && cpu_read) begin
        next_cur.reg_rvalid = 1'b1;
        case (reg_idx)
          `MMD_OFF_MAP:    next_cur.reg_rdata = cur.map;
          `MMD_OFF_EEPOS:  next_cur.reg_rdata = {cur.ee_pos, 4'h0};
          `MMD_OFF_CONFIG: next_cur.reg_rdata = {cur.rom_place, 5'h10, cur.rom_present,
                                                 cur.ee_on};
          `MMD_OFF_MODE:   next_cur.reg_rdata = {cur.boot_rom, special, cur.mode[0], 5'h06};
          default:         next_cur.reg_rdata = 8'h00;
        endcase
      end
    end
    // External bus only in expanded modes.
    next_cur.bus_oe = expanded;
    if (expanded && cpu_valid && dec_sel == MMD_SEL_EXT) begin
      next_cur.pb   = cpu_addr[15:8];
      next_cur.pf   = cpu_addr[7:0];
      next_cur.rw   = cpu_read;
      next_cur.pc_oe = !cpu_read;
      next_cur.pc   = cpu_wdata;
      next_cur.page = cpu_page;
    end else begin
      next_cur.rw    = 1'b1;
      next_cur.pc_oe = 1'b0;
      next_cur.page  = expanded ? cur.page : 4'h0;
    end
    // Data is captured only in cycles that show a read, so writes never echo back.
    if (cur.rw) begin
      next_cur.ext_rdata = port_c_in;
    end
    if (!expanded) begin
      next_cur.pb = 8'h00;
      next_cur.pf = 8'h00;
      next_cur.pc = 8'h00;
    end
    next_cur.sel        = dec_sel;
    next_cur.sel_offset = dec_off;
    // Loader writes and jump.
    // The last store leaves the loader already done, so it is not gated on activity.
    next_cur.ram_wr_en   = bl_wr_en;
    next_cur.ram_wr_addr = bl_wr_addr;
    next_cur.ram_wr_data = bl_wr_data;
    next_cur.jump        = bl_jump;
    next_cur.jump_addr   = bl_jump_addr;
  end

  // Registers the whole state record.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cur      <= '0;
      cur.map  <= `MMD_MAP_RESET;
      cur.ee_pos <= `MMD_EEPOS_RESET;
      cur.rw   <= 1'b1;
      cur.mode <= MMD_MODE_SINGLE;
    end else begin
      cur <= next_cur;
    end
  end

  // ****************************************************************
  // Outputs, each straight from the state record.
  // ****************************************************************
  assign sel            = cur.sel;
  assign sel_offset     = cur.sel_offset;
  assign reg_rdata      = cur.reg_rdata;
  assign reg_rvalid     = cur.reg_rvalid;
  assign ext_rdata      = cur.ext_rdata;
  assign port_b_out     = cur.pb;
  assign port_b_oe      = {8{cur.bus_oe}};
  assign port_f_out     = cur.pf;
  assign port_f_oe      = {8{cur.bus_oe}};
  assign port_c_out     = cur.pc;
  assign port_c_oe      = {8{cur.pc_oe}};
  assign page_out       = cur.page;
  assign read_write     = cur.rw;
  assign ram_wr_en      = cur.ram_wr_en;
  assign ram_wr_addr    = cur.ram_wr_addr;
  assign ram_wr_data    = cur.ram_wr_data;
  assign boot_jump      = cur.jump;
  assign boot_jump_addr = cur.jump_addr;

endmodule : mmd_decoder

// File: mmd_decoder_properties.sv
`timescale 1ns/1ps

// ****************************************************************
// Port checker for the mode and memory map decoder.
// ****************************************************************
module mmd_decoder_chk import mmd_pkg::*; (
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic        mode_a,
  input wire logic [15:0] cpu_addr,
  input wire logic        cpu_valid,
  input wire logic        cpu_read,
  input wire logic [7:0]  cpu_wdata,
  input wire logic        rx_valid,
  input wire logic [7:0]  rx_data,
  input wire logic [2:0]  sel,
  input wire logic        reg_rvalid,
  input wire logic [7:0]  port_b_out,
  input wire logic [7:0]  port_b_oe,
  input wire logic [7:0]  port_f_out,
  input wire logic [7:0]  port_f_oe,
  input wire logic [7:0]  port_c_out,
  input wire logic [7:0]  port_c_oe,
  input wire logic [3:0]  page_out,
  input wire logic        read_write,
  input wire logic        ram_wr_en,
  input wire logic [7:0]  ram_wr_data,
  input wire logic        boot_jump,
  input wire logic [15:0] boot_jump_addr
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // Cycle after an external access was taken in a mode with an expansion bus.
  sequence ext_s;
    sel == MMD_SEL_EXT && mode_a && $past(cpu_valid);
  endsequence

  // Expansion bus relations; mode_a low means single-chip or bootstrap.
  bus_off_a: assert property (!mode_a |-> (port_b_oe | port_f_oe | port_c_oe) == 8'h00)
    else $error("expansion bus driven without an expanded mode");
  addr_out_a: assert property (ext_s |-> {port_b_out, port_f_out} == $past(cpu_addr)
    && port_b_oe == 8'hff && port_f_oe == 8'hff) else $error("address not on ports");
  write_dir_a: assert property (ext_s ##0 !$past(cpu_read) |-> !read_write
    && port_c_oe == 8'hff && port_c_out == $past(cpu_wdata)) else $error("write cycle wrong");
  read_dir_a: assert property (ext_s ##0 $past(cpu_read) |-> read_write
    && port_c_oe == 8'h00) else $error("read cycle wrong");
  page_gate_a: assert property (!mode_a |-> page_out == 4'h0)
    else $error("page bits outside expanded modes");
  jump_entry_a: assert property (boot_jump |-> boot_jump_addr == 16'h0080)
    else $error("loader entry address wrong");
  // A received byte passes the loader register and then the output register.
  boot_store_a: assert property (ram_wr_en |-> $past(rx_valid, 2)
    && ram_wr_data == $past(rx_data, 2)) else $error("loader store wrong");
  reg_answer_a: assert property (sel == MMD_SEL_REGS && $past(cpu_valid && cpu_read)
    |-> reg_rvalid) else $error("register read unanswered");
  rvalid_cause_a: assert property (reg_rvalid |-> $past(cpu_valid && cpu_read)
    && sel == MMD_SEL_REGS) else $error("register answer without read");
endmodule : mmd_decoder_chk

bind mmd_decoder mmd_decoder_chk u_chk (.*);

// File: mmd_ext_mem.sv
`timescale 1ns/1ps

// ****************************************************************
// External memory on the expansion bus.
// ****************************************************************
module mmd_ext_mem (
  input  wire logic       core_clk,
  input  wire logic [7:0] port_f_out,
  input  wire logic       read_write,
  input  wire logic [7:0] port_c_oe,
  input  wire logic [7:0] port_c_out,
  output logic      [7:0] port_c_in
);
  logic [7:0] mem [256];
  logic [7:0] last = 8'h00;

  // Stores the byte while the device drives the data bus low-direction.
  always @(posedge core_clk) begin
    if (!read_write && port_c_oe != 8'h00) begin
      mem[port_f_out] <= port_c_out;
    end
    last <= port_c_in;
  end

  // Drives data only when a read is shown; otherwise a changing pattern.
  always_comb begin
    if (read_write) begin
      port_c_in = mem[port_f_out];
    end else begin
      port_c_in = ~last;
    end
  end
endmodule : mmd_ext_mem

// File: mode_and_memory_map_decoder_test.sv
`timescale 1ns/1ps
`define CHK(a, b, m) total_checks++; if ((a) !== (b)) begin n_mismatch++; $display("unexpected at %0t: %s", $time, m); end

module mode_and_memory_map_decoder_test import mmd_pkg::*;;
  logic        core_clk, resetn, mode_b, mode_a, cfg_rom_placement, cfg_rom_present;
  logic        cfg_eeprom_enable, cpu_valid, cpu_read, rx_valid, reg_rvalid, read_write;
  logic        ram_wr_en, boot_jump;
  logic [15:0] cpu_addr, sel_offset, ram_wr_addr, boot_jump_addr;
  logic [7:0]  cpu_wdata, port_c_in, rx_data, reg_rdata, ext_rdata, port_b_out, port_b_oe;
  logic [7:0]  port_f_out, port_f_oe, port_c_out, port_c_oe, ram_wr_data;
  logic [3:0]  cpu_page, page_out;
  logic [2:0]  sel;
  int          n_mismatch = 0;
  int          total_checks = 0;

  mmd_decoder #(.LARGE_RAM(1'b0), .CHAR_CYCLES(4)) DUT (.*);
  mmd_ext_mem u_mem (.*);

  // Clock at 50 MHz.
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // ****************************************************************
  // Shared tasks.
  // ****************************************************************
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize

  task automatic restart(input logic [1:0] m);
    resetn <= 1'b0;
    {mode_b, mode_a} <= m;
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge core_clk);
  endtask : restart

  task automatic acc(input logic [15:0] a, input logic rd, input logic [7:0] d);
    cpu_addr <= a;
    cpu_read <= rd;
    cpu_wdata <= d;
    cpu_valid <= 1'b1;
    @(posedge core_clk);
    cpu_valid <= 1'b0;
    #1;
  endtask : acc

  task automatic dec(input logic [15:0] a, input logic [2:0] s);
    acc(a, 1'b1, 8'h00);
    `CHK(sel, s, "decode")
  endtask : dec

  task automatic rd(input logic [15:0] a, input logic [7:0] d);
    acc(a, 1'b1, 8'h00);
    `CHK({reg_rvalid, reg_rdata}, {1'b1, d}, "register read")
  endtask : rd

  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic t_expanded();
    restart(2'b11);
    dec(16'h0010, MMD_SEL_REGS);
    `CHK(sel_offset, 16'h0010, "offset")
    dec(16'h0300, MMD_SEL_RAM);
    dec(16'h0fff, MMD_SEL_EEPROM);
    rd(16'h003d, 8'h00);
    acc(16'h003d, 1'b0, 8'h12);
    rd(16'h203d, 8'h12);
    dec(16'h2005, MMD_SEL_REGS);
    dec(16'h1000, MMD_SEL_RAM);
    dec(16'h12ff, MMD_SEL_RAM);
    dec(16'h1300, MMD_SEL_EXT);
    dec(16'h0000, MMD_SEL_EXT);
    acc(16'h203d, 1'b0, 8'h00);
    rd(16'h203d, 8'h12);
    acc(16'h2037, 1'b0, 8'h30);
    rd(16'h2037, 8'h30);
    dec(16'h3d80, MMD_SEL_EEPROM);
    dec(16'h0d80, MMD_SEL_EXT);
    acc(16'h4a5c, 1'b0, 8'h3c);
    `CHK({port_b_out, port_f_out}, 16'h4a5c, "address")
    `CHK({read_write, port_c_oe, port_c_out}, {1'b0, 8'hff, 8'h3c}, "write")
    acc(16'h4a5c, 1'b1, 8'h00);
    `CHK(read_write, 1'b1, "direction")
    @(posedge core_clk);
    #1;
    `CHK(ext_rdata, 8'h3c, "read back")
    $display("test expanded done");
  endtask : t_expanded

  task automatic t_single();
    cfg_rom_placement <= 1'b0;
    restart(2'b10);
    dec(16'ha000, MMD_SEL_ROM);
    dec(16'hffff, MMD_SEL_ROM);
    dec(16'h2000, MMD_SEL_NONE);
    acc(16'h9fff, 1'b0, 8'h55);
    `CHK({sel, port_b_oe, port_c_oe}, {MMD_SEL_NONE, 16'h0}, "no bus")
    repeat (70) @(posedge core_clk);
    acc(16'h003d, 1'b0, 8'h40);
    rd(16'h003d, 8'h00);
    $display("test single done");
  endtask : t_single

  task automatic t_special();
    cfg_rom_placement <= 1'b1;
    restart(2'b01);
    dec(16'ha000, MMD_SEL_EXT);
    acc(16'h003f, 1'b0, 8'h82);
    dec(16'ha000, MMD_SEL_ROM);
    acc(16'h003d, 1'b0, 8'haa);
    dec(16'ha000, MMD_SEL_REGS);
    dec(16'ha080, MMD_SEL_RAM);
    dec(16'ha300, MMD_SEL_RAM);
    dec(16'ha380, MMD_SEL_ROM);
    $display("test special done");
  endtask : t_special

  task automatic t_boot();
    restart(2'b00);
    rd(16'h003c, 8'hc6);
    dec(16'hbe00, MMD_SEL_BOOT);
    // A store shows two edges after its byte: loader register, then output register.
    for (int i = 0; i < 3; i++) begin
      rx_data <= 8'(8'hc0 + i);
      rx_valid <= 1'b1;
      @(posedge core_clk);
      rx_valid <= 1'b0;
      @(posedge core_clk);
      #1;
      `CHK({ram_wr_en, ram_wr_data}, {1'b1, 8'(8'hc0 + i)}, "store")
      `CHK(ram_wr_addr, 16'(16'h0080 + i), "store address")
    end
    repeat (12) begin
      @(posedge core_clk);
      #1;
      `CHK(boot_jump, 1'b0, "early jump")
    end
    for (int i = 0; i < 12 && boot_jump !== 1'b1; i++) begin
      @(posedge core_clk);
      #1;
    end
    `CHK({boot_jump, boot_jump_addr}, {1'b1, 16'h0080}, "jump")
    acc(16'h003c, 1'b0, 8'h00);
    dec(16'hbe00, MMD_SEL_ROM);
    // A full program back to back ends on the byte for the top of RAM.
    restart(2'b00);
    rx_valid <= 1'b1;
    repeat (768) @(posedge core_clk);
    rx_valid <= 1'b0;
    @(posedge core_clk);
    #1;
    `CHK({boot_jump, ram_wr_en, ram_wr_addr}, {2'b11, 16'h037f}, "last byte")
    $display("test boot done");
  endtask : t_boot

  // Main sequence.
  initial begin
    {resetn, mode_b, mode_a, cpu_valid, cpu_read, rx_valid, cpu_addr, cpu_wdata, rx_data} = '0;
    {cfg_rom_placement, cfg_rom_present, cfg_eeprom_enable} = 3'b111;
    cpu_page = 4'h5;
    t_expanded();
    t_single();
    t_special();
    t_boot();
    summarize();
  end

  // Watchdog.
  initial begin
    repeat (3000) @(posedge core_clk);
    n_mismatch++;
    $display("unexpected at %0t: watchdog", $time);
    summarize();
  end
endmodule : mode_and_memory_map_decoder_test
